// ===== core/abc_adder.v
// 8-bit adder with carry in, carry out and carry out of bit 3
module abc_adder (
  // operands
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  // results
  output wire [7:0] sum,
  output wire cout,
  output wire dc
);

  wire [8:0] full;
  wire [4:0] low;

  // full sum and low nibble sum share the same carry in
  assign full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign sum = full[7:0];
  assign cout = full[8];
  assign dc = low[4];

endmodule

// ===== core/abc_alu_top.v
// add and bit-clear datapath with axi4-lite command and status registers
//
// Overview of operation
// - destination selector 0 writes working register, 1 writes addressed register
// - carry is 1 on addition carry, else 0
// - add register with carry: register plus working plus carry, flags Z DC C
// - add register: working plus register, no carry in, flags Z DC C
// - add immediate with carry: working plus immediate plus carry into working
// - add immediate: working plus immediate, no carry in, into working, flags
// - and with register: bitwise and, selected destination, only zero flag
// - bit clear: zero one bit 0..7 of register, flags untouched
// - power-down flag is 1 at power-up or watchdog clear, 0 on sleep
// - timeout flag is 1 at power-up, watchdog clear or sleep, 0 on timeout
// - main register page operands span 0x00 through 0x2F of 0..63
// - function page operands span 0x6..0xF, special page 0x7..0xF
`include "abc_defs.vh"

module abc_alu_top (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // watchdog event from the timer outside
  input wire wdt_timeout,
  // status flags towards the core
  output wire power_down_flag,
  output wire watchdog_expiry_flag
);

  // one-hot execution states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_READ = 3'b010;
  localparam [2:0] ST_EXEC = 3'b100;

  // bus side state
  reg aw_full_q;
  reg [7:0] awaddr_q;
  reg w_full_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg ar_pend_q;
  reg ar_fetch_q;
  reg [7:0] araddr_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // block state
  reg [2:0] state_q;
  reg [31:0] cmd_q;
  reg [7:0] working_register_q;
  reg carry_q;
  reg digit_carry_flag_q;
  reg zero_q;
  reg power_down_flag_q;
  reg watchdog_expiry_flag_q;
  reg bad_op_q;
  reg [7:0] win_addr_q;

  // command fields
  wire [3:0] opc;
  wire dest;
  wire [2:0] bit_idx;
  wire [5:0] op_addr;
  wire [1:0] op_page;
  wire [7:0] op_imm;
  wire [7:0] op_index;
  assign opc = cmd_q[`ABC_CMD_OPC_MSB:`ABC_CMD_OPC_LSB];
  assign dest = cmd_q[`ABC_CMD_DEST_BIT];
  assign bit_idx = cmd_q[`ABC_CMD_BIT_MSB:`ABC_CMD_BIT_LSB];
  assign op_addr = cmd_q[`ABC_CMD_ADDR_MSB:`ABC_CMD_ADDR_LSB];
  assign op_page = cmd_q[`ABC_CMD_PAGE_MSB:`ABC_CMD_PAGE_LSB];
  assign op_imm = cmd_q[`ABC_CMD_IMM_MSB:`ABC_CMD_IMM_LSB];
  assign op_index = {op_page, op_addr};

  // memory and adder wiring
  wire [7:0] mem_rdata;
  reg mem_we;
  reg [7:0] mem_waddr;
  reg [7:0] mem_wdata;
  wire [7:0] mem_raddr;
  wire [7:0] add_b;
  wire add_cin;
  wire [7:0] add_sum;
  wire add_cout;
  wire add_dc;

  // write handshake, register read value and merged write data
  wire do_write;
  wire aw_take;
  wire w_take;
  wire ar_take;
  reg [31:0] cur_val;
  reg wr_mapped;
  reg [31:0] rd_val;
  reg rd_mapped;
  wire [31:0] wmask;
  wire [31:0] wval;
  reg [31:0] status_word;

  // next command decoded from the merged write data
  wire [3:0] new_opc;
  wire [5:0] new_addr;
  wire [1:0] new_page;
  reg new_needs_reg;
  reg new_known;
  reg new_addr_ok;

  assign aw_take = s_axi_awvalid & awready_q;
  assign w_take = s_axi_wvalid & wready_q;
  assign ar_take = s_axi_arvalid & arready_q;
  assign do_write = aw_full_q & w_full_q & ~bvalid_q & (state_q == ST_IDLE);
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wval = (wdata_q & wmask) | (cur_val & ~wmask);
  assign new_opc = wval[`ABC_CMD_OPC_MSB:`ABC_CMD_OPC_LSB];
  assign new_addr = wval[`ABC_CMD_ADDR_MSB:`ABC_CMD_ADDR_LSB];
  assign new_page = wval[`ABC_CMD_PAGE_MSB:`ABC_CMD_PAGE_LSB];

  // status word assembled from the flags and the busy state
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`ABC_ST_C_BIT] = carry_q;
    status_word[`ABC_ST_DC_BIT] = digit_carry_flag_q;
    status_word[`ABC_ST_Z_BIT] = zero_q;
    status_word[`ABC_ST_PD_BIT] = power_down_flag_q;
    status_word[`ABC_ST_TO_BIT] = watchdog_expiry_flag_q;
    status_word[`ABC_ST_BAD_BIT] = bad_op_q;
    status_word[`ABC_ST_BUSY_BIT] = (state_q != ST_IDLE);
  end

  // register view; all values come in as arguments so callers stay sensitive to them
  function [31:0] reg_view;
    input [7:0] off;
    input [31:0] cmd;
    input [7:0] acc;
    input [31:0] st;
    input [7:0] wa;
    input [7:0] wd;
    begin
      reg_view = 32'h0000_0000;
      if (off == `ABC_CMD_OFF) begin
        reg_view = cmd;
      end else if (off == `ABC_ACC_OFF) begin
        reg_view = {24'h00_0000, acc};
      end else if (off == `ABC_STATUS_OFF) begin
        reg_view = st;
      end else if (off == `ABC_WIN_ADDR_OFF) begin
        reg_view = {24'h00_0000, wa};
      end else if (off == `ABC_WIN_DATA_OFF) begin
        reg_view = {24'h00_0000, wd};
      end
    end
  endfunction

  // address decode for the five mapped words
  function is_mapped;
    input [7:0] off;
    begin
      if (off == `ABC_CMD_OFF) begin
        is_mapped = 1'b1;
      end else if (off == `ABC_ACC_OFF) begin
        is_mapped = 1'b1;
      end else if (off == `ABC_STATUS_OFF) begin
        is_mapped = 1'b1;
      end else if (off == `ABC_WIN_ADDR_OFF) begin
        is_mapped = 1'b1;
      end else if (off == `ABC_WIN_DATA_OFF) begin
        is_mapped = 1'b1;
      end else begin
        is_mapped = 1'b0;
      end
    end
  endfunction

  // current values at the pending write and read addresses
  always @* begin
    cur_val = reg_view(awaddr_q, cmd_q, working_register_q, status_word, win_addr_q, mem_rdata);
    wr_mapped = is_mapped(awaddr_q);
    rd_val = reg_view(araddr_q, cmd_q, working_register_q, status_word, win_addr_q, mem_rdata);
    rd_mapped = is_mapped(araddr_q);
  end

  // operand range check per page for a newly written command
  always @* begin
    new_needs_reg = 1'b0;
    new_known = 1'b1;
    new_addr_ok = 1'b0;
    case (new_opc)
      `ABC_OP_ADD_REG_WITH_CARRY: new_needs_reg = 1'b1;
      `ABC_OP_ADD_REGISTER: new_needs_reg = 1'b1;
      `ABC_OP_AND_WITH_REGISTER: new_needs_reg = 1'b1;
      `ABC_OP_BIT_CLEAR: new_needs_reg = 1'b1;
      `ABC_OP_ADD_IMM_WITH_CARRY: new_needs_reg = 1'b0;
      `ABC_OP_ADD_IMMEDIATE: new_needs_reg = 1'b0;
      `ABC_OP_SLEEP: new_needs_reg = 1'b0;
      `ABC_OP_WATCHDOG_CLEAR: new_needs_reg = 1'b0;
      default: new_known = 1'b0;
    endcase
    if (new_page == `ABC_PAGE_R) begin
      new_addr_ok = (new_addr <= `ABC_R_ADDR_MAX);
    end else if (new_page == `ABC_PAGE_F) begin
      new_addr_ok = (new_addr >= `ABC_F_ADDR_MIN) && (new_addr <= `ABC_F_ADDR_MAX);
    end else if (new_page == `ABC_PAGE_S) begin
      new_addr_ok = (new_addr >= `ABC_S_ADDR_MIN) && (new_addr <= `ABC_S_ADDR_MAX);
    end
  end

  // storage reads the operand while busy, the window otherwise
  assign mem_raddr = (state_q == ST_IDLE) ? win_addr_q : op_index;

  abc_regmem u_regmem (
    .aclk(aclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata_q(mem_rdata)
  );

  // second operand and carry in by operation
  assign add_b = ((opc == `ABC_OP_ADD_IMM_WITH_CARRY) || (opc == `ABC_OP_ADD_IMMEDIATE)) ?
                 op_imm : mem_rdata;
  assign add_cin = ((opc == `ABC_OP_ADD_REG_WITH_CARRY) ||
                    (opc == `ABC_OP_ADD_IMM_WITH_CARRY)) ? carry_q : 1'b0;

  abc_adder u_adder (
    .a(working_register_q),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_cout),
    .dc(add_dc)
  );

  // storage write: execution result to a register, or software through the window
  always @* begin
    mem_we = 1'b0;
    mem_waddr = op_index;
    mem_wdata = add_sum;
    if (state_q == ST_EXEC) begin
      if (opc == `ABC_OP_BIT_CLEAR) begin
        mem_we = 1'b1;
        mem_wdata = mem_rdata & ~(8'h01 << bit_idx);
      end else if ((opc == `ABC_OP_ADD_REG_WITH_CARRY) || (opc == `ABC_OP_ADD_REGISTER)) begin
        mem_we = (dest == `ABC_DEST_REGISTER);
      end else if (opc == `ABC_OP_AND_WITH_REGISTER) begin
        mem_we = (dest == `ABC_DEST_REGISTER);
        mem_wdata = working_register_q & mem_rdata;
      end
    end else if (do_write && (awaddr_q == `ABC_WIN_DATA_OFF)) begin
      mem_we = 1'b1;
      mem_waddr = win_addr_q;
      mem_wdata = wval[7:0];
    end
  end

  // axi write channels: hold address and data, answer once both are in
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ABC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[7:0];
        awready_q <= 1'b0;
      end else if (!aw_full_q) begin
        awready_q <= 1'b1;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end else if (!w_full_q) begin
        wready_q <= 1'b1;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `ABC_RESP_OKAY : `ABC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi read: take address, wait for idle storage, fetch, answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      ar_pend_q <= 1'b0;
      ar_fetch_q <= 1'b0;
      araddr_q <= 8'h00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ABC_RESP_OKAY;
    end else begin
      ar_fetch_q <= 1'b0;
      if (ar_take) begin
        arready_q <= 1'b0;
        ar_pend_q <= 1'b1;
        araddr_q <= s_axi_araddr[7:0];
      end else if (!ar_pend_q && !ar_fetch_q && !rvalid_q) begin
        arready_q <= 1'b1;
      end
      if (ar_pend_q && (state_q == ST_IDLE)) begin
        ar_pend_q <= 1'b0;
        ar_fetch_q <= 1'b1;
      end
      if (ar_fetch_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mapped ? rd_val : 32'h0000_0000;
        rresp_q <= rd_mapped ? `ABC_RESP_OKAY : `ABC_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // execution sequence and architectural state
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      cmd_q <= `ABC_CMD_RST;
      working_register_q <= `ABC_ACC_RST;
      carry_q <= 1'b0;
      digit_carry_flag_q <= 1'b0;
      zero_q <= 1'b0;
      power_down_flag_q <= `ABC_PD_RST;
      watchdog_expiry_flag_q <= `ABC_TO_RST;
      bad_op_q <= 1'b0;
      win_addr_q <= `ABC_WIN_ADDR_RST;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (do_write && (awaddr_q == `ABC_CMD_OFF)) begin
            cmd_q <= wval;
            if (new_known && (!new_needs_reg || new_addr_ok)) begin
              state_q <= ST_READ;
            end else begin
              bad_op_q <= 1'b1;
            end
          end
        end
        ST_READ: begin
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          state_q <= ST_IDLE;
          case (opc)
            `ABC_OP_ADD_REG_WITH_CARRY, `ABC_OP_ADD_REGISTER: begin
              if (dest == `ABC_DEST_WORKING) begin
                working_register_q <= add_sum;
              end
              carry_q <= add_cout;
              digit_carry_flag_q <= add_dc;
              zero_q <= (add_sum == 8'h00);
            end
            `ABC_OP_ADD_IMM_WITH_CARRY, `ABC_OP_ADD_IMMEDIATE: begin
              working_register_q <= add_sum;
              carry_q <= add_cout;
              digit_carry_flag_q <= add_dc;
              zero_q <= (add_sum == 8'h00);
            end
            `ABC_OP_AND_WITH_REGISTER: begin
              if (dest == `ABC_DEST_WORKING) begin
                working_register_q <= working_register_q & mem_rdata;
              end
              zero_q <= ((working_register_q & mem_rdata) == 8'h00);
            end
            `ABC_OP_SLEEP: begin
              power_down_flag_q <= 1'b0;
              watchdog_expiry_flag_q <= 1'b1;
            end
            `ABC_OP_WATCHDOG_CLEAR: begin
              power_down_flag_q <= 1'b1;
              watchdog_expiry_flag_q <= 1'b1;
            end
            default: begin
              state_q <= ST_IDLE;
            end
          endcase
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // software writes to plain registers, only while idle
      if (do_write && (awaddr_q == `ABC_ACC_OFF)) begin
        working_register_q <= wval[7:0];
      end
      if (do_write && (awaddr_q == `ABC_WIN_ADDR_OFF)) begin
        win_addr_q <= wval[7:0];
      end
      if (do_write && (awaddr_q == `ABC_STATUS_OFF)) begin
        carry_q <= wval[`ABC_ST_C_BIT];
        digit_carry_flag_q <= wval[`ABC_ST_DC_BIT];
        zero_q <= wval[`ABC_ST_Z_BIT];
        if (wdata_q[`ABC_ST_BAD_BIT] && wstrb_q[0]) begin
          bad_op_q <= 1'b0;
        end
      end
      // a rejected command in the same cycle keeps the error bit set
      if (do_write && (awaddr_q == `ABC_CMD_OFF) &&
          !(new_known && (!new_needs_reg || new_addr_ok))) begin
        bad_op_q <= 1'b1;
      end
      // watchdog expiry wins over a sleep or clear in the same cycle
      if (wdt_timeout) begin
        watchdog_expiry_flag_q <= 1'b0;
      end
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign power_down_flag = power_down_flag_q;
  assign watchdog_expiry_flag = watchdog_expiry_flag_q;

endmodule

// ===== core/abc_regmem.v
// register page storage: one write port, one registered read port
module abc_regmem (
  // clock
  input wire aclk,
  // write port
  input wire we,
  input wire [7:0] waddr,
  input wire [7:0] wdata,
  // read port
  input wire [7:0] raddr,
  output reg [7:0] rdata_q
);

  reg [7:0] mem [0:255];

  // read before write; read data appears one edge after the address
  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule

// ===== dv/abc_alu_chk_sva.sv
// checker for bus handshakes and status flag timing of the datapath block
`include "abc_defs.vh"

module abc_alu_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // watchdog event and status flags
  input wire logic wdt_timeout,
  input wire logic power_down_flag,
  input wire logic watchdog_expiry_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] since_w_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since the last write data take, saturating at 15
  always @(posedge aclk) begin
    if (!aresetn || (s_axi_wvalid && s_axi_wready)) since_w_q <= 4'h0;
    else if (since_w_q != 4'hF) since_w_q <= since_w_q + 4'h1;
  end

  // status flags: reset values, timeout, and only commands move them
  a_rst_flags: assert property (
    $rose(aresetn) |-> power_down_flag && watchdog_expiry_flag)
    else $error("flags not set after reset");
  a_timeout_clears: assert property (
    wdt_timeout |=> !watchdog_expiry_flag)
    else $error("timeout flag not cleared by watchdog event");
  a_pd_cause: assert property (
    !$stable(power_down_flag) |-> since_w_q <= 4'h8)
    else $error("power-down flag moved without a command");
  a_to_rise_cause: assert property (
    $rose(watchdog_expiry_flag) |-> since_w_q <= 4'h8)
    else $error("timeout flag set without a command");
  a_sleep_sets_to: assert property (
    $fell(power_down_flag) |-> watchdog_expiry_flag || $past(wdt_timeout))
    else $error("sleep left the timeout flag clear");

  // bus handshakes: refusal while pending, bounded answers, stable data
  a_wr_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while a response is pending");
  a_wr_answer: assert property (
    s_axi_wvalid && s_axi_wready |-> ##[1:8] s_axi_bvalid)
    else $error("write response missing");
  a_rd_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##[1:5] s_axi_rvalid)
    else $error("read data too early or missing");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

  // main scenarios
  c_timeout: cover property (wdt_timeout);
  c_sleep: cover property ($fell(power_down_flag));
  c_rd_stall: cover property (s_axi_rvalid && !s_axi_rready);
  c_wr_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `ABC_RESP_SLVERR);
endmodule

// ===== dv/tb.sv
// self-checking bench for the add and bit-clear datapath block
`include "abc_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, wdt_timeout = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] rs;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire power_down_flag, watchdog_expiry_flag;
  int error_cnt = 0, compares = 0;

  abc_alu_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wdt_timeout,
    .power_down_flag, .watchdog_expiry_flag);

  // 250 MHz clock
  initial forever #2 aclk = ~aclk;

  task automatic close_out;
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // bus write: address and data together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  // bus read: rready held from the request until rvalid is sampled high
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task automatic rst;
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
  endtask

  // launch a command and wait until busy drops
  task automatic cmd(input logic [3:0] op, input logic dst, input logic [2:0] b,
                     input logic [1:0] pg, input logic [5:0] ad, input logic [7:0] im);
    wr(`ABC_CMD_OFF, {8'h00, im, pg, ad, b, dst, op}, rs);
    do rd(`ABC_STATUS_OFF, rv, rs); while (rv[8] !== 1'b0);
  endtask

  // e is {timeout, power-down} on the ports and in status
  task automatic chkp(input logic [1:0] e);
    `CHK("port flags", e, {watchdog_expiry_flag, power_down_flag})
    rd(`ABC_STATUS_OFF, rv, rs);
    `CHK("status flags", e, rv[4:3])
  endtask

  task automatic wdt;
    @(posedge aclk);
    wdt_timeout <= 1;
    @(posedge aclk);
    wdt_timeout <= 0;
    @(posedge aclk);
  endtask

  // one operation on register 0x2F of the main page, expectations worked out here
  task automatic op_case(input logic [3:0] op, input logic dst, input logic [2:0] b,
      input logic [7:0] ac, input logic [7:0] r0, input logic [2:0] fl, input logic [7:0] im);
    logic [8:0] s;
    logic [7:0] src, res, ea, er;
    logic [2:0] ef;
    logic imo, ci;
    imo = op == `ABC_OP_ADD_IMM_WITH_CARRY || op == `ABC_OP_ADD_IMMEDIATE;
    ci = (op == `ABC_OP_ADD_REG_WITH_CARRY || op == `ABC_OP_ADD_IMM_WITH_CARRY) & fl[0];
    src = imo ? im : r0;
    s = ac + src + ci;
    res = s[7:0];
    ef = {res == 8'h00, ({1'b0, ac[3:0]} + src[3:0] + ci) > 5'h0F, s[8]};
    if (op == `ABC_OP_AND_WITH_REGISTER) begin
      res = ac & r0;
      ef = {res == 8'h00, fl[1:0]};
    end
    if (op == `ABC_OP_BIT_CLEAR) begin
      res = r0 & ~(8'h01 << b);
      ef = fl;
    end
    ea = ac;
    er = r0;
    if (op == `ABC_OP_BIT_CLEAR || (dst && !imo)) er = res;
    else ea = res;
    wr(`ABC_ACC_OFF, {24'h0, ac}, rs);
    wr(`ABC_WIN_ADDR_OFF, 32'h2F, rs);
    wr(`ABC_WIN_DATA_OFF, {24'h0, r0}, rs);
    wr(`ABC_STATUS_OFF, {29'h0, fl}, rs);
    cmd(op, dst, b, `ABC_PAGE_R, 6'h2F, im);
    rd(`ABC_ACC_OFF, rv, rs);
    `CHK("working", ea, rv[7:0])
    rd(`ABC_WIN_DATA_OFF, rv, rs);
    `CHK("register", er, rv[7:0])
    rd(`ABC_STATUS_OFF, rv, rs);
    `CHK("zdc flags", ef, rv[2:0])
  endtask

  // operand pages: {page, address, rejected}
  task automatic t_range;
    logic [8:0] rt [9] = '{9'h05E, 9'h061, 9'h08B, 9'h08C, 9'h09E, 9'h0A1, 9'h10D, 9'h10E,
                           9'h18F};
    for (int i = 0; i < 9; i++) begin
      wr(`ABC_STATUS_OFF, 32'h20, rs);
      cmd(`ABC_OP_ADD_REGISTER, 1'b0, 3'h0, rt[i][8:7], rt[i][6:1], 8'h00);
      rd(`ABC_STATUS_OFF, rv, rs);
      `CHK("bad operand", rt[i][0], rv[5])
    end
  endtask

  task automatic t_bus;
    rd(`ABC_ACC_OFF, rv, rs);
    `CHK("acc reset", `ABC_ACC_RST, rv[7:0])
    `CHK("mapped rresp", `ABC_RESP_OKAY, rs)
    rd(8'h14, rv, rs);
    `CHK("unmapped rresp", `ABC_RESP_SLVERR, rs)
    `CHK("unmapped rdata", 32'h0, rv)
    wr(8'h40, 32'h55, rs);
    `CHK("unmapped bresp", `ABC_RESP_SLVERR, rs)
    wr(`ABC_WIN_ADDR_OFF, 32'h2F, rs);
    `CHK("mapped bresp", `ABC_RESP_OKAY, rs)
  endtask

  task automatic t_power;
    chkp(2'b11);
    wdt();
    chkp(2'b01);
    cmd(`ABC_OP_SLEEP, 1'b0, 3'h0, 2'h0, 6'h00, 8'h00);
    chkp(2'b10);
    wdt();
    chkp(2'b00);
    cmd(`ABC_OP_WATCHDOG_CLEAR, 1'b0, 3'h0, 2'h0, 6'h00, 8'h00);
    chkp(2'b11);
    cmd(`ABC_OP_SLEEP, 1'b0, 3'h0, 2'h0, 6'h00, 8'h00);
    rst();
    @(posedge aclk);
    chkp(2'b11);
  endtask

  // watchdog on a hang
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end

  // main sequence
  initial begin
    rst();
    t_bus();
    op_case(4'h0, 1'b1, 3'h0, 8'h12, 8'h34, 3'b001, 8'h00);
    op_case(4'h1, 1'b0, 3'h0, 8'h12, 8'h34, 3'b001, 8'h00);
    op_case(4'h2, 1'b0, 3'h0, 8'h12, 8'h00, 3'b001, 8'h34);
    op_case(4'h3, 1'b1, 3'h0, 8'hFF, 8'h55, 3'b000, 8'h01);
    op_case(4'h2, 1'b0, 3'h0, 8'h0F, 8'h00, 3'b001, 8'h00);
    op_case(4'h0, 1'b0, 3'h0, 8'hF0, 8'h0F, 3'b001, 8'h00);
    op_case(4'h4, 1'b1, 3'h0, 8'h5A, 8'hAF, 3'b011, 8'h00);
    op_case(4'h4, 1'b0, 3'h0, 8'h0F, 8'hF0, 3'b000, 8'h00);
    op_case(4'h5, 1'b0, 3'h7, 8'h00, 8'hFF, 3'b111, 8'h00);
    op_case(4'h5, 1'b1, 3'h0, 8'h12, 8'h5B, 3'b000, 8'h00);
    t_range();
    t_power();
    close_out();
  end
endmodule

bind abc_alu_top abc_alu_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wdt_timeout, .power_down_flag,
  .watchdog_expiry_flag);

// ===== inc/abc_defs.vh
// constants for the add and bit-clear datapath block
`ifndef ABC_DEFS_VH
`define ABC_DEFS_VH

// register byte offsets on the axi4-lite bus
`define ABC_CMD_OFF 8'h00
`define ABC_ACC_OFF 8'h04
`define ABC_STATUS_OFF 8'h08
`define ABC_WIN_ADDR_OFF 8'h0C
`define ABC_WIN_DATA_OFF 8'h10

// command register fields
`define ABC_CMD_OPC_LSB 0
`define ABC_CMD_OPC_MSB 3
`define ABC_CMD_DEST_BIT 4
`define ABC_CMD_BIT_LSB 5
`define ABC_CMD_BIT_MSB 7
`define ABC_CMD_ADDR_LSB 8
`define ABC_CMD_ADDR_MSB 13
`define ABC_CMD_PAGE_LSB 14
`define ABC_CMD_PAGE_MSB 15
`define ABC_CMD_IMM_LSB 16
`define ABC_CMD_IMM_MSB 23

// status register fields
`define ABC_ST_C_BIT 0
`define ABC_ST_DC_BIT 1
`define ABC_ST_Z_BIT 2
`define ABC_ST_PD_BIT 3
`define ABC_ST_TO_BIT 4
`define ABC_ST_BAD_BIT 5
`define ABC_ST_BUSY_BIT 8

// operation codes
`define ABC_OP_ADD_REG_WITH_CARRY 4'h0
`define ABC_OP_ADD_REGISTER 4'h1
`define ABC_OP_ADD_IMM_WITH_CARRY 4'h2
`define ABC_OP_ADD_IMMEDIATE 4'h3
`define ABC_OP_AND_WITH_REGISTER 4'h4
`define ABC_OP_BIT_CLEAR 4'h5
`define ABC_OP_SLEEP 4'h6
`define ABC_OP_WATCHDOG_CLEAR 4'h7

// operand pages and their legal address ranges
`define ABC_PAGE_R 2'h0
`define ABC_PAGE_F 2'h1
`define ABC_PAGE_S 2'h2
`define ABC_R_ADDR_MIN 6'h00
`define ABC_R_ADDR_MAX 6'h2F
`define ABC_F_ADDR_MIN 6'h06
`define ABC_F_ADDR_MAX 6'h0F
`define ABC_S_ADDR_MIN 6'h07
`define ABC_S_ADDR_MAX 6'h0F

// destination selector values
`define ABC_DEST_WORKING 1'h0
`define ABC_DEST_REGISTER 1'h1

// reset values
`define ABC_CMD_RST 32'h0000_0000
`define ABC_ACC_RST 8'h00
`define ABC_WIN_ADDR_RST 8'h00
`define ABC_PD_RST 1'h1
`define ABC_TO_RST 1'h1

// axi responses
`define ABC_RESP_OKAY 2'h0
`define ABC_RESP_SLVERR 2'h2

`endif
